// file: uart_async_rx.sv
// receiver end: oversampling start detection, voting, parity, flagged fifo
// assumes: rxd is asynchronous; sample tick derived from baud divisor input
// Summary of operation
// - frame, overrun, parity flags readable as status
// - flags stored with frame; data read pops
// - parity checked against received parity bit
// - disable flushes buffer, drops current frame
// - complete flag holds while unread frames remain
// - sample 16x normal, 8x double speed
// - falling edge starts detection, sample one
// - start voted on samples 8-10 or 4-6
// - majority high start is noise, rearm
// - each bit voted on three centre samples
// - frame ends at first stop bit
// - low stop bit sets frame error
// - next start accepted right after stop vote
// - remote rate must stay within ratio limits
// - normal mode error budget 3.0 to 1.5 percent
// - double mode error budget 2.5 to 1.0 percent
// - budget split equally between both clocks
// - stop bit moves frame to buffer if not full, flags complete
// - even parity one when ones count odd
`timescale 1ns/10ps
module uart_async_rx
    import uart_rx_pkg::*;
(
    input  wire logic                          core_clk_i,
    input  wire logic                          rst_n_i,
    uart_line_if.rx_end                        line,
    input  wire logic                          rx_enable_i,
    input  wire logic                          double_speed_i,
    input  wire uart_rx_pkg::parity_mode_e     parity_mode_i,
    input  wire logic [3:0]                    data_bits_i,
    input  wire logic [15:0]                   sample_div_i,
    input  wire logic                          data_read_i,
    output logic [uart_rx_pkg::DATA_MAX_W-1:0] rx_data_o,
    output logic                               frame_error_flag_o,
    output logic                               parity_mismatch_flag_o,
    output logic                               overrun_flag_o,
    output logic                               rx_complete_flag_o
);
    import uart_rx_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_START,
        ST_BITS
    } rx_state_e;

    logic                  sync1_q;
    logic                  sync2_q;
    logic                  line_prev_q;
    logic [15:0]           div_cnt_q;
    logic                  tick;
    rx_state_e             state_q;
    logic [4:0]            samp_q;
    logic [1:0]            votes_q;
    logic [3:0]            bit_idx_q;
    logic [DATA_MAX_W-1:0] shift_q;
    logic                  par_bit_q;
    rx_entry_s             fifo_q [FIFO_DEPTH];
    logic [PTR_W-1:0]      wr_q;
    logic [PTR_W-1:0]      rd_q;
    logic [PTR_W-1:0]      count_q;
    logic [4:0]            spb;
    logic [4:0]            vote_first;
    logic [3:0]            nbits;
    logic [3:0]            last_idx;
    logic                  bit_val;
    logic                  vote_end;
    logic                  push;
    logic                  pop;
    logic                  full;
    logic                  calc_par;
    rx_entry_s             new_entry;

    // two-flop synchroniser on the line
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync1_q     <= 1'b1;
            sync2_q     <= 1'b1;
            line_prev_q <= 1'b1;
        end else begin
            sync1_q     <= line.rxd;
            sync2_q     <= sync1_q;
            // previous sample; follows the line while disabled, so no false edge on enable
            if (tick || !rx_enable_i) begin
                line_prev_q <= sync2_q;
            end
        end
    end

    // sample tick generator
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_cnt_q <= DIV_RESET;
        end else if (!rx_enable_i || div_cnt_q >= sample_div_i) begin
            div_cnt_q <= DIV_RESET;
        end else begin
            div_cnt_q <= div_cnt_q + 16'h0001;
        end
    end
    assign tick = rx_enable_i && (div_cnt_q >= sample_div_i);

    assign spb        = double_speed_i ? SPB_DOUBLE : SPB_NORMAL;
    assign vote_first = double_speed_i ? VOTE_DOUBLE : VOTE_NORMAL;
    assign nbits      = (data_bits_i < FRAME_MIN_W) ? FRAME_MIN_W :
                        (data_bits_i > FRAME_MAX_W) ? FRAME_MAX_W : data_bits_i;
    // index of first stop bit: data bits, plus parity when enabled
    assign last_idx   = (parity_mode_i == PAR_NONE) ? nbits : nbits + 4'h1;
    assign vote_end   = tick && (samp_q == vote_first + 5'h02);
    // majority of three samples, including the current one
    assign bit_val    = (votes_q + {1'b0, sync2_q}) >= 2'h2;
    assign full       = (count_q == PTR_W'(FIFO_DEPTH));
    assign calc_par   = (^(shift_q & ((DATA_MAX_W'(1) << nbits) - DATA_MAX_W'(1))))
                        ^ (parity_mode_i == PAR_ODD);
    assign push       = (state_q == ST_BITS) && vote_end && (bit_idx_q == last_idx);

    always_comb begin
        new_entry            = '0;
        new_entry.data       = shift_q;
        new_entry.frame_err  = ~bit_val;
        new_entry.parity_err = (parity_mode_i != PAR_NONE) && (calc_par != par_bit_q);
        new_entry.overrun    = full;
    end

    // receive state machine
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q   <= ST_IDLE;
            samp_q    <= 5'h00;
            votes_q   <= 2'h0;
            bit_idx_q <= 4'h0;
            shift_q   <= '0;
            par_bit_q <= 1'b0;
        end else if (!rx_enable_i) begin
            state_q <= ST_IDLE;
        end else if (tick) begin
            case (state_q)
                ST_IDLE: begin
                    if (line_prev_q && !sync2_q) begin
                        state_q <= ST_START;
                        samp_q  <= 5'h02;
                        votes_q <= 2'h0;
                    end
                end
                ST_START: begin
                    if (samp_q >= vote_first && !vote_end) begin
                        votes_q <= votes_q + {1'b0, sync2_q};
                    end
                    samp_q <= samp_q + 5'h01;
                    if (vote_end) begin
                        if (bit_val) begin
                            state_q <= ST_IDLE;
                        end else begin
                            state_q   <= ST_BITS;
                            bit_idx_q <= 4'h0;
                            shift_q   <= '0;
                        end
                    end
                end
                ST_BITS: begin
                    if (samp_q == spb) begin
                        samp_q  <= 5'h01;
                        votes_q <= 2'h0;
                    end else begin
                        samp_q <= samp_q + 5'h01;
                        if (samp_q >= vote_first && !vote_end) begin
                            votes_q <= votes_q + {1'b0, sync2_q};
                        end
                    end
                    if (vote_end) begin
                        if (bit_idx_q == last_idx) begin
                            state_q <= ST_IDLE;
                        end else if (bit_idx_q >= nbits) begin
                            par_bit_q <= bit_val;
                        end else begin
                            shift_q[bit_idx_q] <= bit_val;
                        end
                        bit_idx_q <= bit_idx_q + 4'h1;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    assign pop = data_read_i && (count_q != '0);

    // flagged fifo; on overrun the newest entry overwrites nothing
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_q    <= '0;
            rd_q    <= '0;
            count_q <= '0;
            for (int i = 0; i < FIFO_DEPTH; i++) begin
                fifo_q[i] <= '0;
            end
        end else if (!rx_enable_i) begin
            wr_q    <= '0;
            rd_q    <= '0;
            count_q <= '0;
        end else begin
            if (push && !full) begin
                fifo_q[wr_q[0]] <= new_entry;
                wr_q <= wr_q + PTR_W'(1);
            end else if (push && full) begin
                // flag the frame waiting at the tail as followed by a loss
                fifo_q[wr_q[0] ^ 1'b1].overrun <= 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + PTR_W'(1);
            end
            count_q <= count_q + PTR_W'(push && !full) - PTR_W'(pop);
        end
    end

    // registered status view of the oldest entry
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_data_o              <= '0;
            frame_error_flag_o     <= 1'b0;
            parity_mismatch_flag_o <= 1'b0;
            overrun_flag_o         <= 1'b0;
            rx_complete_flag_o     <= 1'b0;
        end else begin
            rx_data_o              <= (count_q != '0) ? fifo_q[rd_q[0]].data : '0;
            frame_error_flag_o     <= (count_q != '0) && fifo_q[rd_q[0]].frame_err;
            parity_mismatch_flag_o <= (count_q != '0) && fifo_q[rd_q[0]].parity_err;
            overrun_flag_o         <= (count_q != '0) && fifo_q[rd_q[0]].overrun;
            rx_complete_flag_o     <= (count_q != '0);
        end
    end
endmodule

// file: uart_rx_pkg.sv
// package: shared constants and types for the async uart receive path
// assumes: both ends, the checker and the bench import it; the interface does not
package uart_rx_pkg;
    localparam int          DATA_MAX_W   = 9;
    localparam int          FIFO_DEPTH   = 2;
    localparam int          PTR_W        = 2;
    localparam logic [4:0]  SPB_NORMAL   = 5'h10;
    localparam logic [4:0]  SPB_DOUBLE   = 5'h08;
    localparam logic [4:0]  VOTE_NORMAL  = 5'h08;
    localparam logic [4:0]  VOTE_DOUBLE  = 5'h04;
    localparam logic [3:0]  FRAME_MIN_W  = 4'h5;
    localparam logic [3:0]  FRAME_MAX_W  = 4'h9;
    localparam logic [15:0] DIV_RESET    = 16'h0001;
    typedef enum logic [1:0] {
        PAR_NONE,
        PAR_EVEN,
        PAR_ODD
    } parity_mode_e;
    typedef struct packed {
        logic [DATA_MAX_W-1:0] data;
        logic                  frame_err;
        logic                  parity_err;
        logic                  overrun;
    } rx_entry_s;
endpackage

// file: uart_line_if.sv
// interface: serial receive line between a remote transmitter and the receiver
// assumes: both ends share core_clk_i; the line idles high
`timescale 1ns/10ps
interface uart_line_if;
    logic rxd;
    modport tx_end (output rxd);
    modport rx_end (input rxd);
endinterface

// file: uart_remote_tx.sv
// transmitter end: remote async sender driving the receive line
// assumes: same core clock; bit period set by the user in clock cycles
`timescale 1ns/10ps
module uart_remote_tx
    import uart_rx_pkg::*;
(
    input  wire logic                               core_clk_i,
    input  wire logic                               rst_n_i,
    uart_line_if.tx_end                             line,
    input  wire logic                               send_i,
    input  wire logic [uart_rx_pkg::DATA_MAX_W-1:0] data_i,
    input  wire logic [3:0]                         data_bits_i,
    input  wire uart_rx_pkg::parity_mode_e          parity_mode_i,
    input  wire logic                               two_stop_i,
    input  wire logic [15:0]                        bit_cycles_i,
    output logic                                    busy_o
);
    import uart_rx_pkg::*;

    logic [DATA_MAX_W+3:0] frame_q;
    logic [3:0]            left_q;
    logic [15:0]           cyc_q;
    logic                  par;
    logic [DATA_MAX_W-1:0] mask;
    logic [3:0]            nbits;
    logic                  txd_q;

    // bit rate kept within the receiver's ratio limits by bit_cycles_i
    assign nbits = (data_bits_i < FRAME_MIN_W) ? FRAME_MIN_W :
                   (data_bits_i > FRAME_MAX_W) ? FRAME_MAX_W : data_bits_i;
    assign mask  = (DATA_MAX_W'(1) << nbits) - DATA_MAX_W'(1);
    assign par   = (^(data_i & mask)) ^ (parity_mode_i == PAR_ODD);
    assign line.rxd = txd_q;

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            frame_q <= '1;
            left_q  <= 4'h0;
            cyc_q   <= 16'h0000;
            txd_q   <= 1'b1;
            busy_o  <= 1'b0;
        end else if (!busy_o) begin
            if (send_i) begin
                // lsb first, then optional parity, then stop bits
                frame_q <= ({{4{1'b1}}, (data_i & mask)} |
                           ({(DATA_MAX_W+4){1'b1}} << nbits))
                           & ~((DATA_MAX_W+4)'(parity_mode_i != PAR_NONE && !par) << nbits);
                left_q  <= nbits + ((parity_mode_i != PAR_NONE) ? 4'h1 : 4'h0)
                           + (two_stop_i ? 4'h2 : 4'h1);
                cyc_q   <= 16'h0001;
                txd_q   <= 1'b0;
                busy_o  <= 1'b1;
            end
        end else if (cyc_q >= bit_cycles_i) begin
            cyc_q <= 16'h0001;
            if (left_q == 4'h0) begin
                busy_o <= 1'b0;
                txd_q  <= 1'b1;
            end else begin
                txd_q   <= frame_q[0];
                frame_q <= {1'b1, frame_q[DATA_MAX_W+3:1]};
                left_q  <= left_q - 4'h1;
            end
        end else begin
            cyc_q <= cyc_q + 16'h0001;
        end
    end
endmodule

// file: uart_rx_assertions.sv
// checker: line and receive status assertions for the joined pair
// assumes: instantiated in the bench beside the line interface
`timescale 1ns/10ps
module uart_rx_assertions
    import uart_rx_pkg::*;
(
    input wire logic                         core_clk_i,
    input wire logic                         rst_n_i,
    input wire logic                         rxd,
    input wire logic                         busy_o,
    input wire logic                         rx_enable_i,
    input wire logic                         data_read_i,
    input wire logic [uart_rx_pkg::DATA_MAX_W-1:0] rx_data_o,
    input wire logic                         frame_error_flag_o,
    input wire logic                         parity_mismatch_flag_o,
    input wire logic                         overrun_flag_o,
    input wire logic                         rx_complete_flag_o
);
    wire hold = rx_complete_flag_o && !data_read_i && rx_enable_i;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    property p_idle; !busy_o |-> rxd; endproperty
    a_idle: assert property (p_idle) else $error("line not idle high");
    property p_start; $rose(busy_o) |-> !rxd; endproperty
    a_start: assert property (p_start) else $error("frame not opened low");
    property p_off; !rx_enable_i |=> ##1 !rx_complete_flag_o; endproperty
    a_off: assert property (p_off) else $error("disable kept frames");
    property p_empty; !rx_complete_flag_o |-> rx_data_o == '0 && !frame_error_flag_o
        && !parity_mismatch_flag_o && !overrun_flag_o; endproperty
    a_empty: assert property (p_empty) else $error("status set while empty");
    property p_hold; hold && !$past(data_read_i) && $past(rx_enable_i)
        |=> rx_complete_flag_o; endproperty
    a_hold: assert property (p_hold) else $error("complete dropped unread");
    property p_keep; hold && !$past(data_read_i) && $past(rx_enable_i)
        |=> $stable(rx_data_o) && $stable(overrun_flag_o); endproperty
    a_keep: assert property (p_keep) else $error("oldest frame changed");
    property p_push; $rose(rx_complete_flag_o) |-> $past(busy_o); endproperty
    a_push: assert property (p_push) else $error("frame out of nowhere");
    property p_first; $rose(rx_complete_flag_o) |-> !overrun_flag_o; endproperty
    a_first: assert property (p_first) else $error("overrun on empty buffer");
    property p_clean; rx_complete_flag_o |-> !parity_mismatch_flag_o
        && !frame_error_flag_o; endproperty
    a_clean: assert property (p_clean) else $error("false error on good frame");
endmodule

// file: uart_async_receiver_recovery_tb.sv
// bench: sender and receiver on one line, second receiver on a bench-driven line
// assumes: sample_div_i of 1, one sample per core cycle, except in the rate scenario
`timescale 1ns/10ps
module uart_async_receiver_recovery_tb;
    import uart_rx_pkg::*;
    logic clk = 1'b0;
    logic rst_n, en, dbl, rd, rd2, snd, two, busy;
    logic rc_a, fe_a, pe_a, ov_a, rc_b, fe_b, pe_b, ov_b;
    logic [3:0] nb;
    logic [8:0] txd, d_a, d_b;
    logic [15:0] bc, div;
    parity_mode_e par;
    int mismatches = 0, checked = 0, cycles = 0;
    wire logic [3:0] st_a = {rc_a, fe_a, pe_a, ov_a};
    wire logic [3:0] st_b = {rc_b, fe_b, pe_b, ov_b};
    uart_line_if line_a ();
    uart_line_if line_b ();
    uart_remote_tx uart_remote_tx_inst (.core_clk_i(clk), .rst_n_i(rst_n), .line(line_a),
        .send_i(snd), .data_i(txd), .data_bits_i(nb), .parity_mode_i(par), .two_stop_i(two),
        .bit_cycles_i(bc), .busy_o(busy));
    uart_async_rx uart_async_rx_inst (.core_clk_i(clk), .rst_n_i(rst_n), .line(line_a),
        .rx_enable_i(en), .double_speed_i(dbl), .parity_mode_i(par), .data_bits_i(nb),
        .sample_div_i(div), .data_read_i(rd), .rx_data_o(d_a),
        .frame_error_flag_o(fe_a), .parity_mismatch_flag_o(pe_a), .overrun_flag_o(ov_a),
        .rx_complete_flag_o(rc_a));
    uart_async_rx uart_async_rx_inst_b (.core_clk_i(clk), .rst_n_i(rst_n), .line(line_b),
        .rx_enable_i(en), .double_speed_i(1'b0), .parity_mode_i(par), .data_bits_i(nb),
        .sample_div_i(16'h0001), .data_read_i(rd2), .rx_data_o(d_b),
        .frame_error_flag_o(fe_b), .parity_mismatch_flag_o(pe_b), .overrun_flag_o(ov_b),
        .rx_complete_flag_o(rc_b));
    uart_rx_assertions uart_rx_assertions_inst (.core_clk_i(clk), .rst_n_i(rst_n),
        .rxd(line_a.rxd), .busy_o(busy), .rx_enable_i(en), .data_read_i(rd),
        .rx_data_o(d_a), .frame_error_flag_o(fe_a), .parity_mismatch_flag_o(pe_a),
        .overrun_flag_o(ov_a), .rx_complete_flag_o(rc_a));
    always #12.5 clk = ~clk;
    task give_verdict();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches = mismatches + 1;
            give_verdict();
        end
    end
    task check(input logic [8:0] seen, input logic [8:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    function logic [8:0] mask(input logic [3:0] n);
        return 9'h1FF >> (4'h9 - n);
    endfunction
    task send(input logic [8:0] d, input logic [3:0] n, input parity_mode_e p, input logic s);
        txd = d;
        nb = n;
        par = p;
        two = s;
        snd = 1'b1;
        @(negedge clk);
        snd = 1'b0;
        repeat (400) if (busy) @(negedge clk);
        repeat (2) @(negedge clk);
    endtask
    task pop(input logic b);
        if (b) rd2 = 1'b1;
        else rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        rd2 = 1'b0;
        @(negedge clk);
    endtask
    task drive_b(input logic [11:0] b, input int n);
        for (int i = 0; i < n; i++) begin
            line_b.rxd = b[i];
            repeat (16) @(negedge clk);
        end
        line_b.rxd = 1'b1;
        repeat (8) @(negedge clk);
    endtask
    task t_frames();
        logic [8:0] d;
        for (int p = 0; p < 3; p++) begin
            for (int n = 5; n < 10; n++) begin
                d = 9'h1A5 ^ 9'(n * 3 + p);
                send(d, 4'(n), parity_mode_e'(p), 1'b0);
                check(d_a, d & mask(4'(n)));
                check({5'h00, st_a}, 9'h008);
                pop(1'b0);
                check({5'h00, st_a}, 9'h000);
            end
        end
    endtask
    task t_double();
        dbl = 1'b1;
        bc = 16'h0008;
        send(9'h0C3, 4'h8, PAR_ODD, 1'b1);
        check(d_a, 9'h0C3);
        check({5'h00, st_a}, 9'h008);
        pop(1'b0);
        dbl = 1'b0;
        bc = 16'h0010;
    endtask
    task t_rate();
        for (int m = 0; m < 4; m++) begin
            dbl = m[1];
            div = m[1] ? 16'h0004 : 16'h0002;
            bc = m[0] ? 16'h0021 : 16'h001F;
            send(9'h0B6, 4'h8, PAR_NONE, !m[0]);
            check(d_a, 9'h0B6);
            check({5'h00, st_a}, 9'h008);
            pop(1'b0);
        end
        dbl = 1'b0;
        div = 16'h0001;
        bc = 16'h0010;
    endtask
    task t_overrun();
        send(9'h011, 4'h8, PAR_NONE, 1'b0);
        send(9'h022, 4'h8, PAR_NONE, 1'b0);
        send(9'h033, 4'h8, PAR_NONE, 1'b0);
        check(d_a, 9'h011);
        check({5'h00, st_a}, 9'h008);
        pop(1'b0);
        check(d_a, 9'h022);
        check({5'h00, st_a}, 9'h009);
        pop(1'b0);
        check({5'h00, st_a}, 9'h000);
    endtask
    task t_disable();
        send(9'h05A, 4'h8, PAR_NONE, 1'b0);
        txd = 9'h0FF;
        snd = 1'b1;
        @(negedge clk);
        snd = 1'b0;
        repeat (60) @(negedge clk);
        en = 1'b0;
        @(negedge clk);
        en = 1'b1;
        repeat (300) @(negedge clk);
        check({5'h00, st_a}, 9'h000);
    endtask
    task t_line_faults();
        nb = 4'h8;
        par = PAR_EVEN;
        drive_b(12'hE78, 11);
        check(d_b, 9'h03C);
        check({5'h00, st_b}, 9'h00A);
        pop(1'b1);
        drive_b(12'h878, 11);
        check({5'h00, st_b}, 9'h00C);
        pop(1'b1);
        line_b.rxd = 1'b0;
        repeat (7) @(negedge clk);
        line_b.rxd = 1'b1;
        repeat (300) @(negedge clk);
        check({5'h00, st_b}, 9'h000);
        drive_b(12'hC78, 11);
        check({5'h00, st_b}, 9'h008);
        pop(1'b1);
    endtask
    initial begin
        rst_n = 1'b0;
        en = 1'b1;
        {dbl, rd, rd2, snd, two} = 5'h00;
        nb = 4'h8;
        txd = 9'h000;
        div = 16'h0001;
        bc = 16'h0010;
        par = PAR_NONE;
        line_b.rxd = 1'b1;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        t_frames();
        t_double();
        t_rate();
        t_overrun();
        t_disable();
        t_line_faults();
        give_verdict();
    end
endmodule
